/* File: rtl/nvcb_map.svh */
// Purpose: Offsets, field positions, reset values, keys and timing counts of the NVM/CRC/unlock bank
// Assumes: 16-bit register words, 6-bit register index
// Notes:   Definitions only
`ifndef NVCB_MAP_SVH
`define NVCB_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define NVCB_ADDR_STATUS      6'h13
`define NVCB_ADDR_USER_CRC    6'h14
`define NVCB_ADDR_EXP_CRC     6'h15
`define NVCB_ADDR_CALC_CRC    6'h16
`define NVCB_ADDR_NVM_CMD     6'h17
`define NVCB_ADDR_CRC_CTRL    6'h18
`define NVCB_ADDR_NVM_KEY     6'h19
`define NVCB_ADDR_CTL_KEY     6'h1a

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define NVCB_BIT_CAL_FAULT    7
`define NVCB_BIT_OPER_STATE   6
`define NVCB_BIT_CRC_MODE     0
`define NVCB_RST_USER_CRC     8'hce
`define NVCB_RST_EXP_CRC      8'h00
`define NVCB_RST_CALC_CRC     8'hff
`define NVCB_RST_BYTE         8'h00

// ----------------------------------------------------------------------------
// Command codes and unlock keys
// ----------------------------------------------------------------------------
`define NVCB_CMD_PROGRAM      8'ha7
`define NVCB_CMD_LOAD         8'ha2
`define NVCB_KEY1             8'h0f
`define NVCB_KEY2             8'h55
`define NVCB_KEY3             8'haa
`define NVCB_KEY4             8'hf0

// ----------------------------------------------------------------------------
// Timing and CRC polynomial
// ----------------------------------------------------------------------------
`define NVCB_CLK_PERIOD_NS    4
`define NVCB_UNLOCK_WINDOW_MS 10
`define NVCB_CRC_PERIOD_MS    2
`define NVCB_UNLOCK_CYC       (`NVCB_UNLOCK_WINDOW_MS * 1000000 / `NVCB_CLK_PERIOD_NS)
`define NVCB_CRC_PERIOD_CYC   (`NVCB_CRC_PERIOD_MS * 1000000 / `NVCB_CLK_PERIOD_NS)
`define NVCB_CRC_POLY         8'h07

`endif

/* File: rtl/nvcb_pkg.sv */
// Purpose: Types shared by the NVM/CRC/unlock bank
// Assumes: nothing
// Notes:   Gray codes along the key sequence
package nvcb_pkg;

    // ------------------------------------------------------------------------
    // Unlock key sequence states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        NVCB_KEY_IDLE = 2'b00,
        NVCB_KEY_GOT1 = 2'b01,
        NVCB_KEY_GOT2 = 2'b11,
        NVCB_KEY_GOT3 = 2'b10
    } nvcb_key_state_t;

    // ------------------------------------------------------------------------
    // CRC engine states
    // ------------------------------------------------------------------------
    typedef enum logic {
        NVCB_CRC_IDLE = 1'b0,
        NVCB_CRC_RUN  = 1'b1
    } nvcb_crc_state_t;

endpackage : nvcb_pkg

/* File: rtl/nvcb_unlock.sv */
// Purpose: Four-key timed unlock sequencer
// Assumes: key_wr is a one-cycle pulse per register write
// Notes:   Any key write drops a held unlock and is judged afresh
`timescale 1ns/1ps
`include "nvcb_map.svh"

module nvcb_unlock #(
    parameter int unsigned WINDOW_CYC = `NVCB_UNLOCK_CYC,
    parameter int unsigned CNT_W      = 22
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Key writes
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    // Result
    output logic            unlocked
);
    import nvcb_pkg::*;

    nvcb_key_state_t  state_reg,    state_next;
    logic [CNT_W-1:0] timer_reg,    timer_next;
    logic             unlocked_reg, unlocked_next;
    logic             expired;
    logic             key_ok;
    logic [7:0]       want_key;

    // ------------------------------------------------------------------------
    // Key expected in each state
    // ------------------------------------------------------------------------
    function automatic logic [7:0] key_for(input nvcb_key_state_t st);
        unique case (st)
            NVCB_KEY_IDLE: key_for = `NVCB_KEY1;
            NVCB_KEY_GOT1: key_for = `NVCB_KEY2;
            NVCB_KEY_GOT2: key_for = `NVCB_KEY3;
            NVCB_KEY_GOT3: key_for = `NVCB_KEY4;
        endcase
    endfunction : key_for

    assign want_key = key_for(state_reg);
    assign expired  = (state_reg != NVCB_KEY_IDLE) && (timer_reg == CNT_W'(WINDOW_CYC - 1));
    assign key_ok   = (key_data == want_key) && !expired;
    assign unlocked = unlocked_reg;

    // Sequencer next state
    always_comb begin
        state_next    = state_reg;
        timer_next    = timer_reg;
        unlocked_next = unlocked_reg;
        if (state_reg != NVCB_KEY_IDLE) begin
            timer_next = timer_reg + CNT_W'(1);
        end
        if (expired) begin
            state_next = NVCB_KEY_IDLE;
            timer_next = '0;
        end
        if (key_wr) begin
            unlocked_next = 1'b0;
            timer_next    = (state_reg == NVCB_KEY_IDLE) ? '0 : timer_next;
            if (!key_ok) begin
                state_next = NVCB_KEY_IDLE;
                timer_next = '0;
            end else begin
                unique case (state_reg)
                    NVCB_KEY_IDLE: state_next = NVCB_KEY_GOT1;
                    NVCB_KEY_GOT1: state_next = NVCB_KEY_GOT2;
                    NVCB_KEY_GOT2: state_next = NVCB_KEY_GOT3;
                    NVCB_KEY_GOT3: begin
                        state_next    = NVCB_KEY_IDLE;
                        timer_next    = '0;
                        unlocked_next = 1'b1;
                    end
                endcase
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg    <= NVCB_KEY_IDLE;
            timer_reg    <= '0;
            unlocked_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            timer_reg    <= timer_next;
            unlocked_reg <= unlocked_next;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    unlock_needs_key4_a: assert property ($rose(unlocked_reg) |-> $past(key_wr) && $past(state_reg) == NVCB_KEY_GOT3)
        else $error("unlock rose without the fourth key");
    window_expiry_idle_a: assert property (expired && !key_wr |=> state_reg == NVCB_KEY_IDLE)
        else $error("sequence survived window expiry");
    wrong_key_idle_a: assert property (key_wr && !key_ok |=> state_reg == NVCB_KEY_IDLE && !unlocked_reg)
        else $error("wrong key did not reset the sequence");
    timer_in_window_a: assert property (state_reg != NVCB_KEY_IDLE |-> timer_reg < CNT_W'(WINDOW_CYC))
        else $error("unlock timer beyond window");

endmodule : nvcb_unlock

/* File: rtl/nvcb_bank.sv */
// Purpose: NVM command, register CRC and keyed unlock register bank
// Assumes: The serial front end turns each frame into one-cycle read or write strobes
// Notes:   Read data is registered and valid one cycle after the read strobe
`timescale 1ns/1ps
`include "nvcb_map.svh"

module nvcb_bank #(
    parameter int unsigned UNLOCK_CYC    = `NVCB_UNLOCK_CYC,
    parameter int unsigned CRC_PERIOD    = `NVCB_CRC_PERIOD_CYC,
    parameter int unsigned IMG_BYTES     = 8,
    parameter logic [2:0]  OPTION_CODE   = 3'h1,   // Arbitrary value
    parameter logic [2:0]  REVISION_CODE = 3'h1    // Arbitrary value
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Register access strobes
    input  wire logic                   reg_wr_en,
    input  wire logic                   reg_rd_en,
    input  wire logic [5:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    output logic      [15:0]            reg_rdata,
    output logic                        reg_rd_valid,
    // Device state inputs
    input  wire logic                   frontend_cal_fault,
    input  wire logic                   operating_state_flag,
    input  wire logic [IMG_BYTES*8-1:0] reg_image,
    // Nonvolatile memory handshake
    output logic                        nvm_program_start,
    output logic                        nvm_load_start,
    input  wire logic                   nvm_op_done,
    // Unlock and fault outputs
    output logic                        nvm_unlocked,
    output logic                        control_unlocked,
    output logic                        crc_mismatch
);
    import nvcb_pkg::*;

    localparam int unsigned IDX_W = (IMG_BYTES > 1) ? $clog2(IMG_BYTES) : 1;

    logic [7:0]       user_crc_reg,  user_crc_next;
    logic [7:0]       exp_crc_reg,   exp_crc_next;
    logic [7:0]       calc_crc_reg,  calc_crc_next;
    logic [7:0]       cmd_reg,       cmd_next;
    logic             mode_reg,      mode_next;
    logic [7:0]       nvm_key_reg,   nvm_key_next;
    logic [7:0]       ctl_key_reg,   ctl_key_next;
    logic [15:0]      rdata_reg,     rdata_next;
    logic             rvalid_reg;
    logic             prog_reg,      prog_next;
    logic             load_reg,      load_next;
    nvcb_crc_state_t  crc_state_reg, crc_state_next;
    logic [IDX_W-1:0] idx_reg,       idx_next;
    logic [7:0]       acc_reg,       acc_next;
    logic [21:0]      period_reg,    period_next;
    logic             mism_reg,      mism_next;
    logic             cmd_accept;
    logic             crc_start;
    logic             crc_last;
    logic             period_hit;
    logic [7:0]       acc_step;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Strobe and index come in as arguments so continuous uses follow them
    function automatic logic is_wr(input logic en, input logic [5:0] ra, input logic [5:0] a);
        is_wr = en && (ra == a);
    endfunction : is_wr

    // One byte through the CRC-8 divider, MSB first
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `NVCB_CRC_POLY) : (c << 1);
        end
        crc8_byte = c;
    endfunction : crc8_byte

    // ------------------------------------------------------------------------
    // Register file and command field
    // ------------------------------------------------------------------------
    // Command taken only when unlocked, idle and a known code
    assign cmd_accept = is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_NVM_CMD) && nvm_unlocked && (cmd_reg == `NVCB_RST_BYTE)
                        && (reg_wdata[7:0] == `NVCB_CMD_PROGRAM || reg_wdata[7:0] == `NVCB_CMD_LOAD);

    // Register file next values and read decode
    always_comb begin
        user_crc_next = user_crc_reg;
        exp_crc_next  = exp_crc_reg;
        cmd_next      = cmd_reg;
        mode_next     = mode_reg;
        nvm_key_next  = nvm_key_reg;
        ctl_key_next  = ctl_key_reg;
        rdata_next    = rdata_reg;
        prog_next     = cmd_accept && (reg_wdata[7:0] == `NVCB_CMD_PROGRAM);
        load_next     = cmd_accept && (reg_wdata[7:0] == `NVCB_CMD_LOAD);
        if (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_USER_CRC)) user_crc_next = reg_wdata[7:0];
        if (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_EXP_CRC))  exp_crc_next  = reg_wdata[7:0];
        if (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_CRC_CTRL)) mode_next     = reg_wdata[`NVCB_BIT_CRC_MODE];
        if (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_NVM_KEY))  nvm_key_next  = reg_wdata[7:0];
        if (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_CTL_KEY))  ctl_key_next  = reg_wdata[7:0];
        if (nvm_op_done) cmd_next = `NVCB_RST_BYTE;
        if (cmd_accept)  cmd_next = reg_wdata[7:0];
        if (reg_rd_en) begin
            unique case (reg_addr)
                `NVCB_ADDR_STATUS:   rdata_next = {8'h00, frontend_cal_fault, operating_state_flag,
                                                   OPTION_CODE, REVISION_CODE};
                `NVCB_ADDR_USER_CRC: rdata_next = {8'h00, user_crc_reg};
                `NVCB_ADDR_EXP_CRC:  rdata_next = {8'h00, exp_crc_reg};
                `NVCB_ADDR_CALC_CRC: rdata_next = {8'h00, calc_crc_reg};
                `NVCB_ADDR_NVM_CMD:  rdata_next = {8'h00, cmd_reg};
                `NVCB_ADDR_CRC_CTRL: rdata_next = {15'h0000, mode_reg};
                `NVCB_ADDR_NVM_KEY:  rdata_next = {8'h00, nvm_key_reg};
                `NVCB_ADDR_CTL_KEY:  rdata_next = {8'h00, ctl_key_reg};
                default:             rdata_next = 16'h0000;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            user_crc_reg <= `NVCB_RST_USER_CRC;
            exp_crc_reg  <= `NVCB_RST_EXP_CRC;
            cmd_reg      <= `NVCB_RST_BYTE;
            mode_reg     <= 1'b0;
            nvm_key_reg  <= `NVCB_RST_BYTE;
            ctl_key_reg  <= `NVCB_RST_BYTE;
            rdata_reg    <= 16'h0000;
            rvalid_reg   <= 1'b0;
            prog_reg     <= 1'b0;
            load_reg     <= 1'b0;
        end else begin
            user_crc_reg <= user_crc_next;
            exp_crc_reg  <= exp_crc_next;
            cmd_reg      <= cmd_next;
            mode_reg     <= mode_next;
            nvm_key_reg  <= nvm_key_next;
            ctl_key_reg  <= ctl_key_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= reg_rd_en;
            prog_reg     <= prog_next;
            load_reg     <= load_next;
        end
    end

    // ------------------------------------------------------------------------
    // Register CRC engine
    // ------------------------------------------------------------------------
    assign period_hit = mode_reg && (period_reg == 22'(CRC_PERIOD - 1));
    assign crc_start  = (crc_state_reg == NVCB_CRC_IDLE)
                        && (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_CRC_CTRL) || period_hit);
    assign crc_last   = (crc_state_reg == NVCB_CRC_RUN) && (idx_reg == IDX_W'(IMG_BYTES - 1));
    assign acc_step   = crc8_byte(acc_reg, reg_image[idx_reg*8 +: 8]);

    // CRC engine next values
    always_comb begin
        crc_state_next = crc_state_reg;
        idx_next       = idx_reg;
        acc_next       = acc_reg;
        calc_crc_next  = calc_crc_reg;
        mism_next      = mism_reg;
        period_next    = (mode_reg && !period_hit) ? period_reg + 22'd1 : 22'd0;
        if (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_CALC_CRC)) calc_crc_next = reg_wdata[7:0];
        if (crc_start) begin
            crc_state_next = NVCB_CRC_RUN;
            idx_next       = '0;
            acc_next       = `NVCB_RST_CALC_CRC;
        end else if (crc_state_reg == NVCB_CRC_RUN) begin
            acc_next = acc_step;
            idx_next = idx_reg + IDX_W'(1);
            if (crc_last) begin
                crc_state_next = NVCB_CRC_IDLE;
                calc_crc_next  = acc_step;
                mism_next      = (acc_step != exp_crc_reg);
            end
        end
    end

    // CRC engine flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            crc_state_reg <= NVCB_CRC_IDLE;
            idx_reg       <= '0;
            acc_reg       <= `NVCB_RST_CALC_CRC;
            calc_crc_reg  <= `NVCB_RST_CALC_CRC;
            period_reg    <= 22'd0;
            mism_reg      <= 1'b0;
        end else begin
            crc_state_reg <= crc_state_next;
            idx_reg       <= idx_next;
            acc_reg       <= acc_next;
            calc_crc_reg  <= calc_crc_next;
            period_reg    <= period_next;
            mism_reg      <= mism_next;
        end
    end

    // ------------------------------------------------------------------------
    // Unlock sequencers
    // ------------------------------------------------------------------------
    nvcb_unlock #(
        .WINDOW_CYC (UNLOCK_CYC),
        .CNT_W      (22)
    ) u_nvm_unlock (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .key_wr   (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_NVM_KEY)),
        .key_data (reg_wdata[7:0]),
        .unlocked (nvm_unlocked)
    );

    nvcb_unlock #(
        .WINDOW_CYC (UNLOCK_CYC),
        .CNT_W      (22)
    ) u_ctl_unlock (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .key_wr   (is_wr(reg_wr_en, reg_addr, `NVCB_ADDR_CTL_KEY)),
        .key_data (reg_wdata[7:0]),
        .unlocked (control_unlocked)
    );

    // Outputs straight from flops
    assign reg_rdata         = rdata_reg;
    assign reg_rd_valid      = rvalid_reg;
    assign nvm_program_start = prog_reg;
    assign nvm_load_start    = load_reg;
    assign crc_mismatch      = mism_reg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence cmd_taken_s;
        cmd_accept && reg_wdata[7:0] == `NVCB_CMD_PROGRAM;
    endsequence
    sequence prog_pulse_s;
        nvm_program_start && !nvm_load_start ##1 !nvm_program_start;
    endsequence

    status_word_a: assert property (reg_rd_en && reg_addr == `NVCB_ADDR_STATUS |=>
                                    reg_rdata[15:8] == 8'h00 && reg_rdata[6] == $past(operating_state_flag)
                                    && reg_rdata[7] == $past(frontend_cal_fault))
        else $error("status word readback wrong");
    user_crc_upper_a: assert property (reg_rd_en && reg_addr == `NVCB_ADDR_USER_CRC |=> reg_rdata[15:8] == 8'h00)
        else $error("user crc upper bits not zero");
    prog_start_a: assert property (cmd_taken_s |=> prog_pulse_s)
        else $error("program command did not pulse once");
    cmd_clear_a: assert property (nvm_op_done && !cmd_accept |=> cmd_reg == 8'h00)
        else $error("command field not cleared on completion");
    periodic_check_a: assert property (period_hit && crc_state_reg == NVCB_CRC_IDLE |=> crc_state_reg == NVCB_CRC_RUN)
        else $error("periodic crc check not started");
    check_length_a: assert property (crc_start |=> (crc_state_reg == NVCB_CRC_RUN) ##(IMG_BYTES) (crc_state_reg == NVCB_CRC_IDLE))
        else $error("crc check length wrong");
    mismatch_flag_a: assert property (crc_last |=> crc_mismatch == (calc_crc_reg != $past(exp_crc_reg)))
        else $error("crc mismatch flag disagrees with compare");
    cmd_locked_a: assert property (reg_wr_en && reg_addr == `NVCB_ADDR_NVM_CMD && !nvm_unlocked && cmd_reg == 8'h00
                                   && !nvm_op_done |=> cmd_reg == 8'h00 && !nvm_program_start && !nvm_load_start)
        else $error("command taken while memory locked");

endmodule : nvcb_bank

/* File: verif/nvcb_nvm_model.sv */
// Purpose: Memory side model answering bulk program and load starts
// Assumes: Start pulses last one cycle
// Notes:   DONE_DLY sets how slowly the memory answers
`timescale 1ns/1ps
module nvcb_nvm_model #(
    parameter int DONE_DLY = 6
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Starts and completion
    input  wire logic nvm_program_start,
    input  wire logic nvm_load_start,
    output logic      nvm_op_done,
    output int        n_prog,
    output int        n_load
);
    int cnt;
    // Count starts and pulse done DONE_DLY cycles later
    always_ff @(posedge sys_clk) begin
        nvm_op_done <= (cnt == 1);
        cnt         <= (cnt > 0) ? cnt - 1 : 0;
        if (!rst_n) begin
            n_prog <= 0;
            n_load <= 0;
            cnt    <= 0;
        end else if (nvm_program_start || nvm_load_start) begin
            n_prog <= n_prog + int'(nvm_program_start);
            n_load <= n_load + int'(nvm_load_start);
            cnt    <= DONE_DLY;
        end
    end
endmodule : nvcb_nvm_model

/* File: verif/test_nvcb_bank.sv */
// Purpose: Self-checking bench of the NVM/CRC/unlock bank
// Assumes: Short unlock window and CRC period parameters
// Notes:   Tasks start and end just after a rising edge
`timescale 1ns/1ps
`include "nvcb_map.svh"
module test_nvcb_bank;
    logic        sys_clk, rst_n, reg_wr_en, reg_rd_en, cal, opst, done, pst, lst;
    logic        nvu, ctu, mis, rdv;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [63:0] img;
    int          n_fail, checks_done, n_prog, n_load, cyc;
    nvcb_bank #(.UNLOCK_CYC(50), .CRC_PERIOD(40)) nvcb_bank_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(rdv), .frontend_cal_fault(cal), .operating_state_flag(opst),
        .reg_image(img), .nvm_program_start(pst), .nvm_load_start(lst), .nvm_op_done(done),
        .nvm_unlocked(nvu), .control_unlocked(ctu), .crc_mismatch(mis));
    nvcb_nvm_model nvcb_nvm_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .nvm_program_start(pst),
        .nvm_load_start(lst), .nvm_op_done(done), .n_prog(n_prog), .n_load(n_load));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(logic [5:0] a, logic [15:0] d);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(string n, logic [5:0] a, logic [15:0] e);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1 chk(n, {reg_rdata[15:1], reg_rdata[0] & rdv}, e);
        @(posedge sys_clk);
    endtask : rd
    task automatic flag(string n, logic v, logic e);
        #1 chk(n, {15'h0, v}, {15'h0, e});
        @(posedge sys_clk);
    endtask : flag
    task automatic keys(logic [5:0] a, logic [7:0] k4);
        wr(a, 16'h000f);
        wr(a, 16'h0055);
        wr(a, 16'h00aa);
        wr(a, {8'h00, k4});
    endtask : keys
    function automatic logic [7:0] crc8(logic [63:0] d);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 0; i < 8; i++) begin
            c = c ^ d[8*i+:8];
            for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction : crc8
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [15:0] e[9];
        e = '{16'h00c9, 16'h00ce, 16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 9; i++) rd("reset value", 6'h13 + 6'(i), e[i]);
        wr(6'h13, 16'h0000);
        rd("status", 6'h13, 16'h00c9);
        wr(6'h14, 16'hffa5);
        rd("user crc", 6'h14, 16'h00a5);
        {cal, opst} <= 2'b10;
        rd("status fault", 6'h13, 16'h0089);
        {cal, opst} <= 2'b01;
        rd("status state", 6'h13, 16'h0049);
    endtask : t_regs
    task automatic t_crc();
        wr(6'h15, {8'h00, crc8(img) ^ 8'h01});
        wr(6'h18, 16'h0000);
        repeat (12) @(posedge sys_clk);
        rd("calc crc", 6'h16, {8'h00, crc8(img)});
        flag("mismatch", mis, 1'b1);
        wr(6'h15, {8'h00, crc8(img)});
        rd("exp crc", 6'h15, {8'h00, crc8(img)});
        wr(6'h18, 16'h0000);
        repeat (12) @(posedge sys_clk);
        flag("mismatch", mis, 1'b0);
        img <= 64'hfedcba9876543210;
        wr(6'h18, 16'h0001);
        repeat (12) @(posedge sys_clk);
        img <= 64'h00ff55aa13579bdf;
        repeat (52) @(posedge sys_clk);
        rd("periodic crc", 6'h16, {8'h00, crc8(64'h00ff55aa13579bdf)});
        rd("crc mode", 6'h18, 16'h0001);
        wr(6'h18, 16'h0000);
        repeat (12) @(posedge sys_clk);
        img <= 64'h0;
        repeat (45) @(posedge sys_clk);
        rd("single crc", 6'h16, {8'h00, crc8(64'h00ff55aa13579bdf)});
    endtask : t_crc
    task automatic t_cmd();
        logic [7:0] c[2];
        c = '{8'ha7, 8'ha2};
        wr(6'h17, 16'h00a7);
        rd("locked cmd", 6'h17, 16'h0000);
        keys(6'h19, 8'h11);
        flag("nvm unlock", nvu, 1'b0);
        keys(6'h19, 8'hf0);
        flag("nvm unlock", nvu, 1'b1);
        for (int i = 0; i < 2; i++) begin
            wr(6'h17, {8'h00, c[i]});
            wr(6'h17, {8'h00, c[1 - i]});
            rd("cmd field", 6'h17, {8'h00, c[i]});
            repeat (12) @(posedge sys_clk);
            rd("cmd cleared", 6'h17, 16'h0000);
        end
        chk("program starts", 16'(n_prog), 16'h0001);
        chk("load starts", 16'(n_load), 16'h0001);
    endtask : t_cmd
    task automatic t_ctl();
        wr(6'h1a, 16'h000f);
        repeat (60) @(posedge sys_clk);
        wr(6'h1a, 16'h0055);
        wr(6'h1a, 16'h00aa);
        wr(6'h1a, 16'h00f0);
        flag("late ctl unlock", ctu, 1'b0);
        keys(6'h1a, 8'hf0);
        flag("ctl unlock", ctu, 1'b1);
    endtask : t_ctl
    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    // Reset then run every scenario
    initial begin
        {rst_n, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
        {cal, opst} = 2'b11;
        img = 64'h0123456789abcdef;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_crc();
        t_cmd();
        t_ctl();
        end_of_test();
    end
endmodule : test_nvcb_bank
